/* fan_drive_status_alarm_regs_tb.sv */
`timescale 1ns/1ps
module fan_drive_status_alarm_regs_tb
	import fdsa_pkg::*;
;
	// ------------------------------------------------------------
	// Stimulus signals and bookkeeping
	// ------------------------------------------------------------
	localparam logic [15:0] DevType = 16'h3C96; // Arbitrary value.
	logic clk, arst_n, runRequest, driveOn, fanResetPin, alarmOutputMode;
	logic motorStop, deratingActive, alarmLed, digitalOut;
	logic [FDSA_NFAULT-2:0] faultPin;
	fdsa_req_t req;
	fdsa_rsp_t rsp;
	fdsa_meas_t meas;
	fdsa_speed_cfg_t speedCfg;
	int error_cnt = 0;
	int n_compared = 0;
	int cyc = 0;
	logic [31:0] rs = 32'h7EC0;
	logic [10:0] latMask = 11'h783;
	logic [7:0] detTbl [11] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h20,
		8'h21, 8'h22, 8'h31, 8'h32, 8'h33, 8'hFF};
	logic [15:0] mapTbl [11] = '{16'h0001, 16'h0002, 16'h0003, 16'h0009,
		16'h000A, 16'h000C, 16'h000D, 16'h000E, 16'h000F, 16'h0011,
		16'h001F};

	// Short counts keep the run brief; expectations follow them.
	fdsa_status_alarm #(.DEVICE_TYPE(DevType), .RETRY_CYCLES(20),
		.DERATE_FAIL_CYCLES(30), .BLINK_SLOT_CYCLES(4),
		.RAMP_STEP_CYCLES(2)) u_fdsa_status_alarm (.clk(clk),
		.arst_n(arst_n), .req(req), .rsp(rsp), .meas(meas),
		.speedCfg(speedCfg), .runRequest(runRequest), .driveOn(driveOn),
		.faultPin(faultPin), .fanResetPin(fanResetPin),
		.alarmOutputMode(alarmOutputMode), .motorStop(motorStop),
		.deratingActive(deratingActive), .alarmLed(alarmLed),
		.digitalOut(digitalOut));
	fdsa_modbus_master u_fdsa_modbus_master (.clk(clk), .req(req),
		.rsp(rsp));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
	endfunction
	function automatic logic [15:0] lim(input logic [15:0] v, m);
		return (v > m) ? m : v;
	endfunction
	// Fault class that each fault pin must report.
	function automatic logic [15:0] fcls(input int n);
		return (n < 3) ? 16'(n + 1) : 16'h0004;
	endfunction
	// Class still held long after the pin drops: latched causes only.
	function automatic logic [15:0] fheld(input int n);
		return latMask[n] ? fcls(n) : 16'h0000;
	endfunction
	// Lit cycles per period: two, three or four blinks of one slot each.
	function automatic logic [15:0] flit(input int n);
		return (n < 2) ? 16'(4 * n + 8) : 16'h0010;
	endfunction
	// Expected word with the fan stopped and no alarm held.
	function automatic logic [15:0] expv(input logic [15:0] a);
		case (a)
			16'h0001: return DevType;
			16'h0002: return speedCfg.lowestSpeedLimit;
			16'h0003: return lim(meas.measuredSpeed, speedCfg.highestSpeedLimit);
			16'h0009: return driveOn ? meas.busVoltage : 16'h0000;
			16'h000C: return meas.motorCurrent;
			16'h000D: return lim(meas.motorVoltage, 16'h08CA);
			16'h000E: return lim(meas.analogInput, 16'h0064);
			16'h000F: return meas.moduleTemperature;
			16'h001F: return meas.absorbedPower;
			default: return 16'h0000;
		endcase
	endfunction
	task automatic chk16(input logic [15:0] g, e);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, e);
		chk16({15'h0000, g}, {15'h0000, e});
	endtask
	task automatic wcyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One read through the master, checking data and exception.
	task automatic rc(input logic [7:0] f, input logic [15:0] a, ed,
		input logic [7:0] ee);
		fdsa_rsp_t r;
		u_fdsa_modbus_master.xfer(f, a, r);
		chk1(r.valid, 1'b1);
		chk16(r.data, ed);
		chk16({8'h00, r.exception}, {8'h00, ee});
	endtask
	// Lit cycles over one full eight-slot blink period.
	task automatic led(input logic [15:0] e);
		logic [15:0] c;
		c = '0;
		repeat (32) begin
			@(posedge clk);
			#1;
			c += {15'h0000, alarmLed};
		end
		chk16(c, e);
	endtask
	task automatic close_out;
		$display("Compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Clock, timeout and main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// A hang is cut short well beyond the expected run length.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 10000) begin
			error_cnt++;
			close_out;
		end
	end
	initial begin
		arst_n = 1'b0;
		{runRequest, fanResetPin, alarmOutputMode} = '0;
		driveOn = 1'b1;
		faultPin = '0;
		meas = '0;
		speedCfg = '{16'h0078, 16'h0064, 16'h008C};
		wcyc(20);
		arst_n = 1'b1;
		for (int j = 0; j < 8; j++) begin
			for (int k = 0; k < 7; k++) begin
				rs = lfsr(rs);
				meas[k*16 +: 16] = rs[31:16];
			end
			meas.moduleTemperature = meas.moduleTemperature % 16'h02EF;
			driveOn = rs[0];
			if (j == 0) meas = {16'h008C, 16'h0FA0, 16'h1234, 16'h08CA,
				16'h0064, 16'h02EE, 16'h0050};
			if (j == 1) meas = {16'h008D, 16'h0001, 16'hFFFF, 16'h08CB,
				16'h0065, 16'h0000, 16'hFFFF};
			foreach (mapTbl[a]) rc(8'h04, mapTbl[a], expv(mapTbl[a]), 8'h00);
		end
		foreach (detTbl[k]) rc(8'h06 + 8'(k), 16'h0001, 16'h0000, 8'h01);
		foreach (detTbl[k]) rc(8'h04, 16'h0020 + 16'(k * 3), 16'h0000, 8'h02);
		led(16'h0004);
		for (int i = 0; i < 11; i++) begin
			alarmOutputMode = i[0];
			faultPin[i] = 1'b1;
			wcyc(5);
			rc(8'h04, 16'h000A, fcls(i), 8'h00);
			rc(8'h04, 16'h0011, {8'h00, detTbl[i]}, 8'h00);
			chk1(motorStop, 1'b1);
			chk1(digitalOut, alarmOutputMode);
			if (latMask[i]) led(flit(i));
			faultPin[i] = 1'b0;
			// Every alarm must still be held 4 cycles after its cause drops; the retry delay counts from the alarm.
			wcyc(4);
			rc(8'h04, 16'h000A, fcls(i), 8'h00);
			wcyc(40);
			rc(8'h04, 16'h000A, fheld(i), 8'h00);
			chk1(motorStop, latMask[i]);
			fanResetPin = 1'b1;
			wcyc(3);
			fanResetPin = 1'b0;
			wcyc(6);
			rc(8'h04, 16'h0011, 16'h0000, 8'h00);
			chk1(motorStop, 1'b0);
		end
		meas.moduleTemperature = 16'h0320;
		wcyc(3);
		chk1(deratingActive, 1'b1);
		wcyc(40);
		rc(8'h04, 16'h0011, 16'h0071, 8'h00);
		chk1(motorStop, 1'b1);
		meas.moduleTemperature = 16'h02BC;
		wcyc(5);
		rc(8'h04, 16'h000A, 16'h0000, 8'h00);
		chk1(motorStop, 1'b0);
		rc(8'h04, 16'h0002, 16'h0064, 8'h00);
		runRequest = 1'b1;
		wcyc(60);
		rc(8'h04, 16'h0002, 16'h0078, 8'h00);
		speedCfg.targetSpeed = 16'h00C8;
		wcyc(60);
		rc(8'h04, 16'h0002, 16'h008C, 8'h00);
		speedCfg.targetSpeed = 16'h0032;
		wcyc(120);
		rc(8'h04, 16'h0002, 16'h0064, 8'h00);
		close_out;
	end
endmodule

/* fdsa_modbus_master.sv */
`timescale 1ns/1ps
module fdsa_modbus_master
	import fdsa_pkg::*;
(
	input wire logic clk,
	output fdsa_req_t req,
	input wire fdsa_rsp_t rsp
);
	// Idle bus carries no request.
	initial req = '0;
	// One transfer: strobe for one cycle, answer taken in the next.
	// Released fields go to the inverse so stale values never match.
	task automatic xfer(input logic [7:0] f, input logic [15:0] a,
		output fdsa_rsp_t r);
		@(posedge clk);
		#1;
		req = '{valid: 1'b1, func: f, addr: a};
		@(posedge clk);
		#1;
		r = rsp;
		req = '{valid: 1'b0, func: ~f, addr: ~a};
	endtask
endmodule

/* fdsa_pkg.sv */
package fdsa_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned FDSA_CLK_HZ = 10_000_000;
	localparam int unsigned FDSA_RETRY_DELAY_S = 5;
	localparam int unsigned FDSA_RETRY_CYCLES = FDSA_RETRY_DELAY_S * FDSA_CLK_HZ;
	localparam int unsigned FDSA_DERATE_FAIL_S = 60;
	localparam int unsigned FDSA_DERATE_FAIL_CYCLES =
		FDSA_DERATE_FAIL_S * FDSA_CLK_HZ;
	localparam int unsigned FDSA_BLINK_SLOT_MS = 125;
	localparam int unsigned FDSA_BLINK_SLOT_CYCLES =
		FDSA_BLINK_SLOT_MS * (FDSA_CLK_HZ / 1000);
	localparam int unsigned FDSA_RAMP_STEP_MS = 1;
	localparam int unsigned FDSA_RAMP_STEP_CYCLES =
		FDSA_RAMP_STEP_MS * (FDSA_CLK_HZ / 1000);

	// ----------------------------------------------------------------
	// Register numbers of the read-input-registers map
	// ----------------------------------------------------------------
	localparam logic [15:0] FDSA_REG_DEVICE_TYPE_CODE = 16'h0001;
	localparam logic [15:0] FDSA_REG_SPEED_REFERENCE_RPM = 16'h0002;
	localparam logic [15:0] FDSA_REG_MEASURED_SPEED_RPM = 16'h0003;
	localparam logic [15:0] FDSA_REG_BUS_VOLTAGE_DECIVOLT = 16'h0009;
	localparam logic [15:0] FDSA_REG_FAULT_CLASS = 16'h000A;
	localparam logic [15:0] FDSA_REG_MOTOR_CURRENT_MA = 16'h000C;
	localparam logic [15:0] FDSA_REG_MOTOR_VOLTAGE_DECIVOLT = 16'h000D;
	localparam logic [15:0] FDSA_REG_ANALOG_INPUT_DECIVOLT = 16'h000E;
	localparam logic [15:0] FDSA_REG_MODULE_TEMPERATURE = 16'h000F;
	localparam logic [15:0] FDSA_REG_FAULT_DETAIL = 16'h0011;
	localparam logic [15:0] FDSA_REG_ABSORBED_POWER_WATTS = 16'h001F;

	// Arbitrary neutral identification value.
	localparam logic [15:0] FDSA_DEVICE_TYPE_DEFAULT = 16'h5A01;

	// ----------------------------------------------------------------
	// Protocol function and exception codes
	// ----------------------------------------------------------------
	localparam logic [7:0] FDSA_FN_READ_INPUT = 8'h04;
	localparam logic [7:0] FDSA_EXC_NONE = 8'h00;
	localparam logic [7:0] FDSA_EXC_ILLEGAL_FUNCTION = 8'h01;
	localparam logic [7:0] FDSA_EXC_ILLEGAL_ADDRESS = 8'h02;

	// ----------------------------------------------------------------
	// Limits and thresholds
	// ----------------------------------------------------------------
	localparam logic [15:0] FDSA_MOTOR_VOLTAGE_MAX = 16'h08CA;
	localparam logic [15:0] FDSA_ANALOG_INPUT_MAX = 16'h0064;
	localparam logic [15:0] FDSA_DERATE_TEMP = 16'h02EE;
	localparam logic [15:0] FDSA_CODE_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// Fault sources, in priority order, and their codes
	// ----------------------------------------------------------------
	localparam int FDSA_NFAULT = 12;
	localparam int FDSA_FAULT_OVERTEMP = 11;
	localparam logic [7:0] FDSA_FAULT_CLASS_TBL [FDSA_NFAULT] = '{
		8'h01, 8'h02, 8'h03, 8'h04, 8'h04, 8'h04,
		8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04};
	localparam logic [7:0] FDSA_FAULT_DETAIL_TBL [FDSA_NFAULT] = '{
		8'h00, 8'h00, 8'h00, 8'h01, 8'h20, 8'h21,
		8'h22, 8'h31, 8'h32, 8'h33, 8'hFF, 8'h71};
	// Bit set means latched stop, clear means self retry.
	localparam logic [FDSA_NFAULT-1:0] FDSA_LATCHED_MASK = 12'h783;

	localparam logic [2:0] FDSA_BLINKS_NORMAL = 3'h1;
	localparam logic [2:0] FDSA_BLINKS_MEMORY = 3'h2;
	localparam logic [2:0] FDSA_BLINKS_SHORT = 3'h3;
	localparam logic [2:0] FDSA_BLINKS_OTHER = 3'h4;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		FDSA_ST_NORMAL = 3'b001,
		FDSA_ST_LATCHED = 3'b010,
		FDSA_ST_RETRY = 3'b100
	} fdsa_state_t;

	typedef struct packed {
		logic [15:0] faultClass;
		logic [15:0] faultDetail;
	} fdsa_alarm_t;

	typedef struct packed {
		logic [15:0] measuredSpeed;
		logic [15:0] busVoltage;
		logic [15:0] motorCurrent;
		logic [15:0] motorVoltage;
		logic [15:0] analogInput;
		logic [15:0] moduleTemperature;
		logic [15:0] absorbedPower;
	} fdsa_meas_t;

	typedef struct packed {
		logic [15:0] targetSpeed;
		logic [15:0] lowestSpeedLimit;
		logic [15:0] highestSpeedLimit;
	} fdsa_speed_cfg_t;

	typedef struct packed {
		logic valid;
		logic [7:0] func;
		logic [15:0] addr;
	} fdsa_req_t;

	typedef struct packed {
		logic valid;
		logic [7:0] exception;
		logic [15:0] data;
	} fdsa_rsp_t;

endpackage

/* fdsa_status_alarm.sv */
`timescale 1ns/1ps
// Behaviour
// - Read-only register returns a fixed device-type identification code.
// - Speed reference starts at lowest limit, ramps to target, stays clamped.
// - Measured speed reads zero up to the highest speed limit.
// - Bus voltage in tenths of a volt, zero while the drive is off.
// - Fault class holds zero to four, read together with fault detail.
// - Fault detail holds zero to 255, read together with fault class.
// - Motor current reports peak line current in milliamps.
// - Motor voltage reports peak phase voltage, never above 2250 counts.
// - Analog input reports tenths of a volt, zero to 100 counts.
// - Module temperature above 75 degrees starts derating until it settles.
// - Failed derating stops the fan and alarms; clears below 75 degrees.
// - Measured power reports absorbed watts.
// - Latched-stop alarm stops at once; only a fan reset restarts it.
// - Self-retry alarm signals, then retries automatically after seconds.
// - Alarms appear on registers, blinking LED and digital output together.
// - No fault means both fault registers zero and no protective action.
// - Detail zero: class 1 memory, 2 short latched; 3 synchronism retries.
// - Class 4 details 1,32-34,113 retry; 49-51 and 255 latch.
// - In alarm mode the digital output is low normally, high in alarm.
// - LED blinks 1/s normal, 2 memory, 3 short, 4 for other alarms.
module fdsa_status_alarm
	import fdsa_pkg::*;
#(
	parameter logic [15:0] DEVICE_TYPE = FDSA_DEVICE_TYPE_DEFAULT,
	parameter int unsigned RETRY_CYCLES = FDSA_RETRY_CYCLES,
	parameter int unsigned DERATE_FAIL_CYCLES = FDSA_DERATE_FAIL_CYCLES,
	parameter int unsigned BLINK_SLOT_CYCLES = FDSA_BLINK_SLOT_CYCLES,
	parameter int unsigned RAMP_STEP_CYCLES = FDSA_RAMP_STEP_CYCLES
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire fdsa_req_t req,
	output fdsa_rsp_t rsp,
	input wire fdsa_meas_t meas,
	input wire fdsa_speed_cfg_t speedCfg,
	input wire logic runRequest,
	input wire logic driveOn,
	input wire logic [FDSA_NFAULT-2:0] faultPin,
	input wire logic fanResetPin,
	input wire logic alarmOutputMode,
	output logic motorStop,
	output logic deratingActive,
	output logic alarmLed,
	output logic digitalOut
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [FDSA_NFAULT-1:0] pinMeta_q;
	logic [FDSA_NFAULT-1:0] pinSync_q;
	logic resetSeen_q;

	// Fault pins and the user fan reset arrive asynchronously.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pinMeta_q <= '0;
			pinSync_q <= '0;
		end else begin
			pinMeta_q <= {fanResetPin, faultPin};
			pinSync_q <= pinMeta_q;
		end
	end

	// Edge memory so a held reset button acts only once.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			resetSeen_q <= 1'b0;
		end else begin
			resetSeen_q <= pinSync_q[FDSA_NFAULT-1];
		end
	end

	logic fanResetPulse;
	assign fanResetPulse = pinSync_q[FDSA_NFAULT-1] & ~resetSeen_q;

	// ----------------------------------------------------------------
	// Thermal derating
	// ----------------------------------------------------------------
	logic overTemp;
	logic overTempTrip_q;
	logic [31:0] derateCnt_q;
	fdsa_state_t state_q;

	assign overTemp = meas.moduleTemperature > FDSA_DERATE_TEMP;

	// Derating time is counted; running out means equilibrium failed.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			derateCnt_q <= '0;
			overTempTrip_q <= 1'b0;
		end else if (!overTemp) begin
			derateCnt_q <= '0;
			overTempTrip_q <= 1'b0;
		end else if (derateCnt_q >= DERATE_FAIL_CYCLES - 1) begin
			overTempTrip_q <= 1'b1;
		end else begin
			derateCnt_q <= derateCnt_q + 32'h0000_0001;
		end
	end

	// Derating is only meaningful while the motor is allowed to run.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			deratingActive <= 1'b0;
		end else begin
			deratingActive <= overTemp & (state_q == FDSA_ST_NORMAL);
		end
	end

	// ----------------------------------------------------------------
	// Fault priority selection
	// ----------------------------------------------------------------
	logic [FDSA_NFAULT-1:0] faultVec;
	logic anyFault;
	logic [7:0] selClass;
	logic [7:0] selDetail;
	logic selLatched;

	assign faultVec = {overTempTrip_q, pinSync_q[FDSA_NFAULT-2:0]};
	assign anyFault = |faultVec;

	// Lowest index wins; overtemperature has the lowest priority.
	always_comb begin
		selClass = 8'h00;
		selDetail = 8'h00;
		selLatched = 1'b0;
		for (int i = FDSA_NFAULT - 1; i >= 0; i--) begin
			if (faultVec[i]) begin
				selClass = FDSA_FAULT_CLASS_TBL[i];
				selDetail = FDSA_FAULT_DETAIL_TBL[i];
				selLatched = FDSA_LATCHED_MASK[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// Alarm handler
	// ----------------------------------------------------------------
	fdsa_alarm_t alarm_q;
	logic retryOverTemp_q;
	logic [31:0] retryCnt_q;

	// Class and detail share one register so a read never sees a mix.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= FDSA_ST_NORMAL;
			alarm_q <= '0;
			retryOverTemp_q <= 1'b0;
			retryCnt_q <= '0;
		end else begin
			case (state_q)
				FDSA_ST_NORMAL: begin
					retryCnt_q <= '0;
					if (anyFault) begin
						alarm_q.faultClass <= {8'h00, selClass};
						alarm_q.faultDetail <= {8'h00, selDetail};
						retryOverTemp_q <= ~selLatched & overTempTrip_q &
							~|faultVec[FDSA_NFAULT-2:0];
						state_q <= selLatched ? FDSA_ST_LATCHED :
							FDSA_ST_RETRY;
					end else begin
						alarm_q <= '0;
					end
				end
				FDSA_ST_LATCHED: begin
					// A stuck cause simply re-latches on the next cycle.
					if (fanResetPulse) begin
						alarm_q.faultClass <= FDSA_CODE_RESET;
						alarm_q.faultDetail <= FDSA_CODE_RESET;
						state_q <= FDSA_ST_NORMAL;
					end
				end
				FDSA_ST_RETRY: begin
					if (retryOverTemp_q) begin
						if (!overTemp) begin
							alarm_q <= '0;
							state_q <= FDSA_ST_NORMAL;
						end
					end else if (retryCnt_q >= RETRY_CYCLES - 1) begin
						alarm_q <= '0;
						state_q <= FDSA_ST_NORMAL;
					end else begin
						retryCnt_q <= retryCnt_q + 32'h0000_0001;
					end
				end
				default: begin
					state_q <= FDSA_ST_NORMAL;
					alarm_q <= '0;
				end
			endcase
		end
	end

	// The motor is held off in either alarm state.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			motorStop <= 1'b1;
		end else begin
			motorStop <= (state_q != FDSA_ST_NORMAL) | anyFault;
		end
	end

	// ----------------------------------------------------------------
	// Alarm indication outputs
	// ----------------------------------------------------------------
	logic [31:0] slotCnt_q;
	logic [2:0] slot_q;
	logic [2:0] blinks;

	// Eight slots per second; each blink takes one on and one off slot.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			slotCnt_q <= '0;
			slot_q <= '0;
		end else if (slotCnt_q >= BLINK_SLOT_CYCLES - 1) begin
			slotCnt_q <= '0;
			slot_q <= slot_q + 3'h1;
		end else begin
			slotCnt_q <= slotCnt_q + 32'h0000_0001;
		end
	end

	always_comb begin
		case (alarm_q.faultClass[7:0])
			8'h00: blinks = FDSA_BLINKS_NORMAL;
			8'h01: blinks = FDSA_BLINKS_MEMORY;
			8'h02: blinks = FDSA_BLINKS_SHORT;
			default: blinks = FDSA_BLINKS_OTHER;
		endcase
	end

	// LED, registers and digital output all follow the same alarm word.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			alarmLed <= 1'b0;
			digitalOut <= 1'b0;
		end else begin
			alarmLed <= ~slot_q[0] & ({1'b0, slot_q[2:1]} < blinks);
			digitalOut <= alarmOutputMode &
				(alarm_q.faultClass != FDSA_CODE_RESET);
		end
	end

	// ----------------------------------------------------------------
	// Speed reference ramp
	// ----------------------------------------------------------------
	logic [15:0] speedRef_q;
	logic [31:0] rampCnt_q;
	logic [15:0] targetClamped;

	always_comb begin
		targetClamped = speedCfg.targetSpeed;
		if (targetClamped < speedCfg.lowestSpeedLimit) begin
			targetClamped = speedCfg.lowestSpeedLimit;
		end
		if (targetClamped > speedCfg.highestSpeedLimit) begin
			targetClamped = speedCfg.highestSpeedLimit;
		end
	end

	// One rpm per step; a stopped motor restarts from the lowest limit.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			speedRef_q <= '0;
			rampCnt_q <= '0;
		end else if (!runRequest || motorStop) begin
			speedRef_q <= speedCfg.lowestSpeedLimit;
			rampCnt_q <= '0;
		end else if (rampCnt_q >= RAMP_STEP_CYCLES - 1) begin
			rampCnt_q <= '0;
			if (speedRef_q < targetClamped) begin
				speedRef_q <= speedRef_q + 16'h0001;
			end else if (speedRef_q > targetClamped) begin
				speedRef_q <= speedRef_q - 16'h0001;
			end
		end else begin
			rampCnt_q <= rampCnt_q + 32'h0000_0001;
		end
	end

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	logic [15:0] rdData;
	logic rdHit;

	always_comb begin
		rdHit = 1'b1;
		rdData = 16'h0000;
		case (req.addr)
			FDSA_REG_DEVICE_TYPE_CODE: rdData = DEVICE_TYPE;
			FDSA_REG_SPEED_REFERENCE_RPM: rdData = speedRef_q;
			FDSA_REG_MEASURED_SPEED_RPM: begin
				rdData = (meas.measuredSpeed > speedCfg.highestSpeedLimit) ?
					speedCfg.highestSpeedLimit : meas.measuredSpeed;
			end
			FDSA_REG_BUS_VOLTAGE_DECIVOLT: begin
				rdData = driveOn ? meas.busVoltage : 16'h0000;
			end
			FDSA_REG_FAULT_CLASS: rdData = alarm_q.faultClass;
			FDSA_REG_MOTOR_CURRENT_MA: rdData = meas.motorCurrent;
			FDSA_REG_MOTOR_VOLTAGE_DECIVOLT: begin
				rdData = (meas.motorVoltage > FDSA_MOTOR_VOLTAGE_MAX) ?
					FDSA_MOTOR_VOLTAGE_MAX : meas.motorVoltage;
			end
			FDSA_REG_ANALOG_INPUT_DECIVOLT: begin
				rdData = (meas.analogInput > FDSA_ANALOG_INPUT_MAX) ?
					FDSA_ANALOG_INPUT_MAX : meas.analogInput;
			end
			FDSA_REG_MODULE_TEMPERATURE: rdData = meas.moduleTemperature;
			FDSA_REG_FAULT_DETAIL: rdData = alarm_q.faultDetail;
			FDSA_REG_ABSORBED_POWER_WATTS: rdData = meas.absorbedPower;
			default: rdHit = 1'b0;
		endcase
	end

	// Any function other than a read is refused before the address.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rsp <= '0;
		end else begin
			rsp.valid <= req.valid;
			rsp.data <= '0;
			rsp.exception <= FDSA_EXC_NONE;
			if (req.valid) begin
				if (req.func != FDSA_FN_READ_INPUT) begin
					rsp.exception <= FDSA_EXC_ILLEGAL_FUNCTION;
				end else if (!rdHit) begin
					rsp.exception <= FDSA_EXC_ILLEGAL_ADDRESS;
				end else begin
					rsp.data <= rdData;
				end
			end
		end
	end

endmodule

/* fdsa_status_alarm_asserts.sv */
`timescale 1ns/1ps
module fdsa_status_alarm_chk
	import fdsa_pkg::*;
#(
	parameter logic [15:0] DEVICE_TYPE = FDSA_DEVICE_TYPE_DEFAULT
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire fdsa_req_t req,
	input wire fdsa_rsp_t rsp,
	input wire fdsa_meas_t meas,
	input wire logic driveOn,
	input wire logic [FDSA_NFAULT-2:0] faultPin,
	input wire logic alarmOutputMode,
	input wire logic motorStop,
	input wire logic deratingActive,
	input wire logic digitalOut
);
	// ------------------------------------------------------------
	// Answer timing and register contents
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// A taken read of the input-register map.
	logic rd;
	assign rd = req.valid && req.func == FDSA_FN_READ_INPUT;

	chk_rsp_next: assert property (req.valid |=> rsp.valid)
		else $error("answer missing one cycle after request");
	chk_rsp_idle: assert property (!req.valid |=>
		!rsp.valid && rsp.data == 16'h0000 && rsp.exception == 8'h00)
		else $error("answer without request");
	chk_write_refused: assert property (
		req.valid && req.func != FDSA_FN_READ_INPUT |=>
		rsp.exception == FDSA_EXC_ILLEGAL_FUNCTION && rsp.data == 16'h0000)
		else $error("non-read function not refused");
	chk_type_code: assert property (
		rd && req.addr == FDSA_REG_DEVICE_TYPE_CODE |=>
		rsp.data == DEVICE_TYPE && rsp.exception == FDSA_EXC_NONE)
		else $error("type code wrong");
	chk_class_range: assert property (
		rd && req.addr == FDSA_REG_FAULT_CLASS |=> rsp.data <= 16'h0004)
		else $error("fault class out of range");
	chk_detail_range: assert property (
		rd && req.addr == FDSA_REG_FAULT_DETAIL |=> rsp.data <= 16'h00FF)
		else $error("fault detail out of range");
	chk_vmotor_max: assert property (
		rd && req.addr == FDSA_REG_MOTOR_VOLTAGE_DECIVOLT |=>
		rsp.data <= FDSA_MOTOR_VOLTAGE_MAX)
		else $error("motor voltage above limit");
	chk_analog_max: assert property (
		rd && req.addr == FDSA_REG_ANALOG_INPUT_DECIVOLT |=>
		rsp.data <= FDSA_ANALOG_INPUT_MAX)
		else $error("analog input above limit");
	chk_vbus_off: assert property (
		rd && req.addr == FDSA_REG_BUS_VOLTAGE_DECIVOLT && !driveOn &&
		!$past(driveOn) |=> rsp.data == 16'h0000)
		else $error("bus voltage nonzero with drive off");

	// ------------------------------------------------------------
	// Protective outputs
	// ------------------------------------------------------------
	chk_derate_cold: assert property (
		$past(meas.moduleTemperature) <= FDSA_DERATE_TEMP |-> !deratingActive)
		else $error("derating while cool");
	chk_dout_off: assert property (
		!$past(alarmOutputMode) |-> !digitalOut)
		else $error("digital output high outside alarm mode");
	chk_short_stop: assert property (
		$rose(faultPin[1]) |-> ##[1:4] motorStop)
		else $error("short circuit did not stop motor");

	cover property (rd ##1 rsp.exception == FDSA_EXC_ILLEGAL_ADDRESS);
	cover property ($rose(deratingActive));
	cover property ($rose(motorStop) ##1 digitalOut);
endmodule

bind fdsa_status_alarm fdsa_status_alarm_chk #(
	.DEVICE_TYPE(DEVICE_TYPE)
) u_chk (
	.clk(clk),
	.arst_n(arst_n),
	.req(req),
	.rsp(rsp),
	.meas(meas),
	.driveOn(driveOn),
	.faultPin(faultPin),
	.alarmOutputMode(alarmOutputMode),
	.motorStop(motorStop),
	.deratingActive(deratingActive),
	.digitalOut(digitalOut)
);
